// >>> hw/tcac_pkg.sv
// Purpose: Shared constants and types for the two-channel alarm control block.
// Assumes: 200 MHz clock; 16-bit register words reached by register index.
// Notes: Register indices follow the holding-register numbering of the device.
package tcac_pkg;
    // Register indices (holding register numbers).
    localparam logic [15:0] TCAC_IDX_DOUT = 16'h9C4D;
    localparam logic [15:0] TCAC_IDX_STATUS = 16'h9C4E;
    localparam logic [15:0] TCAC_IDX_TRIG_LO1 = 16'h9C55;
    localparam logic [15:0] TCAC_IDX_TRIG_HI1 = 16'h9C57;
    localparam logic [15:0] TCAC_IDX_TRIG_LO2 = 16'h9C59;
    localparam logic [15:0] TCAC_IDX_TRIG_HI2 = 16'h9C5B;
    localparam logic [15:0] TCAC_IDX_CTRL = 16'h9C5D;
    // Control word field positions.
    localparam int TCAC_CH_STRIDE = 4;
    localparam int TCAC_B_EN = 0;
    localparam int TCAC_B_OUT = 1;
    localparam int TCAC_B_POL = 2;
    localparam int TCAC_B_LOCK = 3;
    localparam int TCAC_B_VPOFF = 8;
    localparam int TCAC_B_SFOFF = 9;
    localparam int TCAC_B_SPZERO = 10;
    localparam int TCAC_B_VCLOSE = 11;
    // Status word field positions.
    localparam int TCAC_S_CH1 = 0;
    localparam int TCAC_S_CH2 = 1;
    localparam int TCAC_S_VP = 2;
    localparam int TCAC_S_SF = 3;
    // Reset values.
    localparam logic [15:0] TCAC_CTRL_RST = 16'h0000;
    localparam logic [15:0] TCAC_TRIG_RST = 16'h0000;
    // Valve power level that counts as full power.
    localparam logic [15:0] TCAC_VP_FULL = 16'h0C80;
    // Valve power timeout: 5 minutes at 200 MHz.
    localparam longint TCAC_VP_TIME_S = 300;
    localparam longint TCAC_CLK_HZ = 200000000;
    localparam longint TCAC_VP_CYCLES = TCAC_VP_TIME_S * TCAC_CLK_HZ;
    // Valve modes.
    typedef enum logic [1:0] {
        TCAC_VM_AUTO = 2'b01,
        TCAC_VM_CLOSED = 2'b10,
        TCAC_VM_PURGE = 2'b11
    } tcac_vmode_t;
endpackage : tcac_pkg

// >>> hw/tcac_if.sv
// Purpose: Carrier between the alarm top and its per-channel comparators.
// Assumes: One clock domain.
// Notes: Top drives settings and clears; the channel drives its status.
`timescale 1ns/1ps
interface tcac_if;
    logic enable;
    logic polarity;
    logic lock;
    logic [15:0] value;
    logic [15:0] trig_lo;
    logic [15:0] trig_hi;
    logic clear;
    logic status;
    modport top (output enable, polarity, lock, value, trig_lo, trig_hi, clear, input status);
    modport chan (input enable, polarity, lock, value, trig_lo, trig_hi, clear, output status);
endinterface : tcac_if

// >>> hw/tcac_channel.sv
// Purpose: One threshold alarm channel with hysteresis and lock mode.
// Assumes: Settings and value are synchronous to clk.
// Notes: Status is the channel alarm state.
`timescale 1ns/1ps
module tcac_channel
    import tcac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    tcac_if.chan ch
);
    logic cond_q;
    logic cond_d;
    logic stat_q;
    logic stat_d;
    wire above_hi = ch.value > ch.trig_hi;
    wire below_lo = ch.value < ch.trig_lo;

    // Hysteresis condition; strict compare so equality never triggers.
    assign cond_d = !ch.enable ? 1'b0 :
        ch.polarity ? (above_hi ? 1'b1 : (below_lo ? 1'b0 : cond_q)) :
        (below_lo ? 1'b1 : (above_hi ? 1'b0 : cond_q));
    // Status follows the condition, or latches in lock mode until cleared; set wins.
    assign stat_d = !ch.enable ? 1'b0 :
        !ch.lock ? cond_d :
        (cond_d ? 1'b1 : (ch.clear ? 1'b0 : stat_q));

    // State registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            cond_q <= 1'b0;
            stat_q <= 1'b0;
        end else begin
            cond_q <= cond_d;
            stat_q <= stat_d;
        end
    end
    assign ch.status = stat_q;

    // Latched status survives the condition until a clear.
    a_lock_holds: assert property (@(posedge clk) disable iff (rst)
        ch.lock && ch.enable && stat_q && !ch.clear && $stable(ch.lock) |=> stat_q)
        else $error("locked status dropped without clear");
    // Disabled channel is inert.
    a_disabled_inert: assert property (@(posedge clk) disable iff (rst)
        !ch.enable |=> !stat_q) else $error("disabled channel raised status");
    // Equality with the high point never raises an idle upward alarm.
    a_equal_no_trig: assert property (@(posedge clk) disable iff (rst)
        ch.enable && ch.polarity && !cond_q && ch.value == ch.trig_hi |=> !cond_q)
        else $error("alarm raised on equality");
    // Upward alarm stays set inside the dead band.
    a_hyst_band: assert property (@(posedge clk) disable iff (rst)
        ch.enable && ch.polarity && cond_q && !below_lo |=> cond_q)
        else $error("alarm cleared inside dead band");
    // Downward alarm sets below the low point.
    a_down_set: assert property (@(posedge clk) disable iff (rst)
        ch.enable && !ch.polarity && below_lo |=> cond_q)
        else $error("downward alarm not set");
endmodule : tcac_channel

// >>> hw/tcac_top.sv
// Purpose: Two-channel threshold alarm unit with valve and set point overrides.
// Assumes: Register accesses arrive as one-cycle strobes with a register index.
// Notes: Digital outputs, set point and valve mode are registered.
// Behaviour
// - Channel inert unless its enable bit set.
// - Output-enable routes alarm state to digital output.
// - Routed output ignores data register; unrouted follows it.
// - Polarity selects below or above comparison.
// - Without lock, status follows alarm condition.
// - With lock, status holds until written zero.
// - Full valve power five minutes zeroes set point.
// - Sensor failure alarm when enabled by zero.
// - Channel one alarm may zero set point, highest.
// - Channel one alarm may close valve, restore after.
// - Overrides act at once, supersede other settings.
// - Upward alarm sets above high, clears below low.
// - Equality never raises an alarm.
// - Status word bits: ch1, ch2, valve, sensor.
// - Valve bit clearable by zero; sensor bit not.
`timescale 1ns/1ps
module tcac_top
    import tcac_pkg::*;
#(
    parameter longint VP_CYCLES = TCAC_VP_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [15:0] reg_idx,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] mon_value1,
    input wire logic [15:0] mon_value2,
    input wire logic [15:0] valve_power,
    input wire logic sensor_fault_pin,
    input wire logic [15:0] host_set_point,
    input wire tcac_vmode_t host_valve_mode,
    output logic [1:0] digital_out,
    output logic [15:0] set_point_out,
    output tcac_vmode_t valve_mode_out
);
    logic [15:0] ctrl_q;
    logic [15:0] trig_lo_q [2];
    logic [15:0] trig_hi_q [2];
    logic [1:0] dout_q;
    logic vp_alarm_q;
    logic sf_meta_q;
    logic sf_sync_q;
    logic [39:0] vp_cnt_q;
    logic [1:0] dig_q;
    logic [15:0] sp_q;
    tcac_vmode_t vm_q;
    logic [1:0] chan_stat;
    tcac_if chan_bus [2] ();

    // Address decoding and write strobes.
    wire wr_ctrl = reg_wr && reg_idx == TCAC_IDX_CTRL;
    wire wr_stat = reg_wr && reg_idx == TCAC_IDX_STATUS;
    wire wr_dout = reg_wr && reg_idx == TCAC_IDX_DOUT;

    // Per-channel comparator instances.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign chan_bus[i].enable = ctrl_q[i*TCAC_CH_STRIDE + TCAC_B_EN];
        assign chan_bus[i].polarity = ctrl_q[i*TCAC_CH_STRIDE + TCAC_B_POL];
        assign chan_bus[i].lock = ctrl_q[i*TCAC_CH_STRIDE + TCAC_B_LOCK];
        assign chan_bus[i].value = (i == 0) ? mon_value1 : mon_value2;
        assign chan_bus[i].trig_lo = trig_lo_q[i];
        assign chan_bus[i].trig_hi = trig_hi_q[i];
        assign chan_bus[i].clear = wr_stat && !reg_wdata[TCAC_S_CH1 + i];
        assign chan_stat[i] = chan_bus[i].status;
        tcac_channel u_chan (
            .clk(clk),
            .rst(rst),
            .ch(chan_bus[i])
        );
    end

    // Control, trigger and data-out registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= TCAC_CTRL_RST;
            dout_q <= 2'b00;
            trig_lo_q <= '{TCAC_TRIG_RST, TCAC_TRIG_RST};
            trig_hi_q <= '{TCAC_TRIG_RST, TCAC_TRIG_RST};
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata;
            if (wr_dout) dout_q <= reg_wdata[1:0];
            if (reg_wr && reg_idx == TCAC_IDX_TRIG_LO1) trig_lo_q[0] <= reg_wdata;
            if (reg_wr && reg_idx == TCAC_IDX_TRIG_HI1) trig_hi_q[0] <= reg_wdata;
            if (reg_wr && reg_idx == TCAC_IDX_TRIG_LO2) trig_lo_q[1] <= reg_wdata;
            if (reg_wr && reg_idx == TCAC_IDX_TRIG_HI2) trig_hi_q[1] <= reg_wdata;
        end
    end

    // Valve power timer runs only while power stays at full; enabled by zero.
    // The count saturates, so a long stall at full power cannot wrap and re-arm it.
    wire vp_en = !ctrl_q[TCAC_B_VPOFF];
    wire vp_full = valve_power == TCAC_VP_FULL;
    wire vp_done = vp_cnt_q >= 40'(VP_CYCLES - 1);
    wire vp_set = vp_en && vp_full && vp_done;
    always_ff @(posedge clk) begin
        if (rst) begin
            vp_cnt_q <= 40'h00_0000_0000;
            vp_alarm_q <= 1'b0;
        end else begin
            vp_cnt_q <= (vp_en && vp_full) ? (vp_done ? vp_cnt_q : vp_cnt_q + 40'd1) : '0;
            if (vp_set) vp_alarm_q <= 1'b1;
            else if (wr_stat && !reg_wdata[TCAC_S_VP]) vp_alarm_q <= 1'b0;
        end
    end

    // Sensor fault pin synchroniser.
    // Only the second stage feeds logic; the first may still be settling.
    always_ff @(posedge clk) begin
        if (rst) begin
            sf_meta_q <= 1'b0;
            sf_sync_q <= 1'b0;
        end else begin
            sf_meta_q <= sensor_fault_pin;
            sf_sync_q <= sf_meta_q;
        end
    end
    wire sf_alarm = sf_sync_q && !ctrl_q[TCAC_B_SFOFF];

    // Output routing and channel-one overrides.
    // Data-out writes still land while routed, so unrouting shows the newest word.
    wire ch1_alarm = chan_stat[0];
    logic [1:0] dig_d;
    assign dig_d[0] = ctrl_q[TCAC_B_OUT] ? chan_stat[0] : dout_q[0];
    assign dig_d[1] = ctrl_q[TCAC_CH_STRIDE + TCAC_B_OUT] ? chan_stat[1] : dout_q[1];
    wire sp_zero = (ch1_alarm && ctrl_q[TCAC_B_SPZERO]) || vp_alarm_q;
    wire [15:0] sp_d = sp_zero ? 16'h0000 : host_set_point;
    wire vclose = ch1_alarm && ctrl_q[TCAC_B_VCLOSE];
    tcac_vmode_t vm_d;
    assign vm_d = vclose ? TCAC_VM_CLOSED : host_valve_mode;

    always_ff @(posedge clk) begin
        if (rst) begin
            dig_q <= 2'b00;
            sp_q <= 16'h0000;
            vm_q <= TCAC_VM_AUTO;
        end else begin
            dig_q <= dig_d;
            sp_q <= sp_d;
            vm_q <= vm_d;
        end
    end
    assign digital_out = dig_q;
    assign set_point_out = sp_q;
    assign valve_mode_out = vm_q;

    // Register read-back; status word layout.
    // Unmapped indices read as zero so a stray read cannot show stale data.
    wire [15:0] status_word = {12'h000, sf_alarm, vp_alarm_q, chan_stat};
    assign reg_rdata = (reg_idx == TCAC_IDX_CTRL) ? ctrl_q :
        (reg_idx == TCAC_IDX_STATUS) ? status_word :
        (reg_idx == TCAC_IDX_DOUT) ? {14'h0000, dout_q} :
        (reg_idx == TCAC_IDX_TRIG_LO1) ? trig_lo_q[0] :
        (reg_idx == TCAC_IDX_TRIG_HI1) ? trig_hi_q[0] :
        (reg_idx == TCAC_IDX_TRIG_LO2) ? trig_lo_q[1] :
        (reg_idx == TCAC_IDX_TRIG_HI2) ? trig_hi_q[1] : 16'h0000;

    // Routed output follows the alarm one cycle later.
    a_route_out: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[TCAC_B_OUT] |=> digital_out[0] == $past(chan_stat[0]))
        else $error("routed output does not follow alarm");
    // Unrouted output shows the data register.
    a_unrouted_data: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[TCAC_B_OUT] |=> digital_out[0] == $past(dout_q[0]))
        else $error("unrouted output lost data value");
    // Set point zero override wins.
    a_sp_zero: assert property (@(posedge clk) disable iff (rst)
        ch1_alarm && ctrl_q[TCAC_B_SPZERO] |=> set_point_out == 16'h0000)
        else $error("set point not forced to zero");
    // Valve mode returns to the host mode whenever the close override is off.
    a_valve_close: assert property (@(posedge clk) disable iff (rst)
        !vclose |=> valve_mode_out == $past(host_valve_mode))
        else $error("valve mode not restored");
    // Valve timeout raises the valve alarm.
    a_vp_timeout: assert property (@(posedge clk) disable iff (rst)
        vp_set |=> vp_alarm_q ##1 set_point_out == 16'h0000)
        else $error("valve timeout did not zero set point");
    // Sensor bit survives a zero write.
    a_sf_sticky: assert property (@(posedge clk) disable iff (rst)
        wr_stat && !reg_wdata[TCAC_S_SF] && sf_alarm && sf_meta_q && !wr_ctrl
        |=> status_word[TCAC_S_SF]) else $error("sensor bit cleared by write");
    // Channel-one alarm with the close option forces the valve closed.
    a_valve_forced: assert property (@(posedge clk) disable iff (rst)
        ch1_alarm && ctrl_q[TCAC_B_VCLOSE] |=> valve_mode_out == TCAC_VM_CLOSED)
        else $error("valve not closed on alarm");
    // Routed second output follows the second alarm one cycle later.
    a_route_two: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[TCAC_CH_STRIDE + TCAC_B_OUT] |=> digital_out[1] == $past(chan_stat[1]))
        else $error("second routed output does not follow alarm");
    // Unrouted second output shows the data register.
    a_unrouted_two: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[TCAC_CH_STRIDE + TCAC_B_OUT] |=> digital_out[1] == $past(dout_q[1]))
        else $error("second unrouted output lost data value");
    // Data-out register captures a write even while the output is routed.
    a_dout_hold: assert property (@(posedge clk) disable iff (rst)
        wr_dout |=> dout_q == $past(reg_wdata[1:0]))
        else $error("data out write not captured");
    // A zero write clears the valve bit when no new timeout is pending.
    a_vp_clear: assert property (@(posedge clk) disable iff (rst)
        vp_alarm_q && wr_stat && !reg_wdata[TCAC_S_VP] && !vp_set |=> !vp_alarm_q)
        else $error("valve bit not cleared by zero write");
    // A disabled valve alarm keeps its timer at zero.
    a_vp_disabled: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[TCAC_B_VPOFF] |=> vp_cnt_q == 40'h00_0000_0000)
        else $error("valve timer ran while disabled");
    // The valve alarm never rises before the full timeout has elapsed.
    a_vp_no_early: assert property (@(posedge clk) disable iff (rst)
        !vp_alarm_q && vp_cnt_q < 40'(VP_CYCLES - 1) |=> !vp_alarm_q)
        else $error("valve alarm raised before timeout");
    // A fault held on the pin reaches the enabled status bit after two stages.
    a_sf_raise: assert property (@(posedge clk) disable iff (rst)
        sensor_fault_pin ##1 sensor_fault_pin ##1 !ctrl_q[TCAC_B_SFOFF] |-> sf_alarm)
        else $error("sensor failure not reported");
    // Without a channel-one or valve alarm the host set point passes through.
    a_sp_follow: assert property (@(posedge clk) disable iff (rst)
        !chan_stat[0] && !vp_alarm_q |=> set_point_out == $past(host_set_point))
        else $error("set point overridden without alarm");
endmodule : tcac_top

// >>> tb/tcac_host_model.sv
// Purpose: Register host that writes and reads words of the alarm block.
// Assumes: Requests change at the falling edge of clk.
// Notes: A write strobe lasts one cycle; reads take the combinational data.
`timescale 1ns/1ps
module tcac_host_model (
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic [15:0] reg_idx,
    output logic [15:0] reg_wdata
);
    // The bus is idle at time zero.
    initial begin
        reg_wr = 1'b0;
        reg_idx = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // A write is taken at the one rising edge under the strobe.
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_idx = idx;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // A read is taken at the rising edge under its index; the task returns at a falling edge.
    task automatic rd(input logic [15:0] idx, output logic [15:0] d);
        @(negedge clk);
        reg_idx = idx;
        @(posedge clk);
        d = reg_rdata;
        @(negedge clk);
    endtask : rd
endmodule : tcac_host_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the two-channel alarm block.
// Assumes: Inputs change at the falling edge; the valve timeout is shortened.
// Notes: Expected values are worked out here from the control settings.
`timescale 1ns/1ps
module testbench;
    import tcac_pkg::*;
    localparam longint VPC = 20;
    logic clk, rst, reg_wr, sf;
    logic [15:0] reg_idx, reg_wdata, reg_rdata, m1, m2, vp, hsp, spo, rv;
    logic [1:0] dout;
    tcac_vmode_t hvm, vmo;
    int mismatches, n_checks;
    // Design and host.
    tcac_top #(.VP_CYCLES(VPC)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mon_value1(m1), .mon_value2(m2), .valve_power(vp), .sensor_fault_pin(sf),
        .host_set_point(hsp), .host_valve_mode(hvm), .digital_out(dout),
        .set_point_out(spo), .valve_mode_out(vmo));
    tcac_host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata));
    // Clock of 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Reads a register and compares it.
    task automatic rchk(input logic [15:0] idx, input logic [15:0] e);
        i_host.rd(idx, rv);
        chk("register", e, rv);
    endtask : rchk
    // Compares the three registered outputs.
    task automatic ochk(input logic [1:0] d, input logic [15:0] s, input tcac_vmode_t v);
        chk("digital_out", {14'h0, d}, {14'h0, dout});
        chk("set_point_out", s, spo);
        chk("valve_mode_out", {14'h0, v}, {14'h0, vmo});
    endtask : ochk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hang.
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        rst = 1'b1;
        {m1, m2, vp, sf} = '0;
        hvm = TCAC_VM_AUTO;
        mismatches = 0;
        n_checks = 0;
        rv = 16'($urandom(68));
        hsp = 16'h0001 + 16'($urandom % 1000);
        step(16);
        rst = 1'b0;
        rchk(TCAC_IDX_CTRL, TCAC_CTRL_RST);
        rchk(TCAC_IDX_TRIG_HI1, TCAC_TRIG_RST);
        rchk(16'h9C5E, 16'h0000);
        ochk(2'b00, hsp, TCAC_VM_AUTO);
        // Channel one upward with output routed.
        i_host.wr(TCAC_IDX_TRIG_LO1, 16'h0064);
        i_host.wr(TCAC_IDX_TRIG_HI1, 16'h00C8);
        i_host.wr(TCAC_IDX_CTRL, 16'h0007);
        rchk(TCAC_IDX_CTRL, 16'h0007);
        m1 = 16'h00C8;
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        m1 = 16'h00C9 + 16'($urandom % 50);
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0001);
        ochk(2'b01, hsp, TCAC_VM_AUTO);
        m1 = 16'h0096;
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0001);
        m1 = 16'h0063;
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        // Disabled channel and data out register.
        i_host.wr(TCAC_IDX_CTRL, 16'h0006);
        m1 = 16'h00FA;
        i_host.wr(TCAC_IDX_DOUT, 16'h0003);
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        ochk(2'b10, hsp, TCAC_VM_AUTO);
        i_host.wr(TCAC_IDX_CTRL, 16'h0000);
        step(3);
        ochk(2'b11, hsp, TCAC_VM_AUTO);
        i_host.wr(TCAC_IDX_DOUT, 16'h0000);
        // Channel two downward in lock mode.
        i_host.wr(TCAC_IDX_TRIG_LO2, 16'h0032);
        i_host.wr(TCAC_IDX_TRIG_HI2, 16'h003C);
        m2 = 16'h0032;
        i_host.wr(TCAC_IDX_CTRL, 16'h00B0);
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        m2 = 16'h0031;
        step(3);
        m2 = 16'h0046;
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0002);
        ochk(2'b10, hsp, TCAC_VM_AUTO);
        i_host.wr(TCAC_IDX_STATUS, 16'h0000);
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        ochk(2'b00, hsp, TCAC_VM_AUTO);
        // Channel one overrides.
        hvm = TCAC_VM_PURGE;
        i_host.wr(TCAC_IDX_CTRL, 16'h0C05);
        m1 = 16'h00C9;
        step(3);
        ochk(2'b00, 16'h0000, TCAC_VM_CLOSED);
        m1 = 16'h0063;
        step(3);
        ochk(2'b00, hsp, TCAC_VM_PURGE);
        // Valve power timeout, disabled then enabled.
        i_host.wr(TCAC_IDX_CTRL, 16'h0100);
        vp = TCAC_VP_FULL;
        step(int'(VPC) + 5);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        i_host.wr(TCAC_IDX_CTRL, 16'h0000);
        step(int'(VPC) - 5);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        step(10);
        rchk(TCAC_IDX_STATUS, 16'h0004);
        ochk(2'b00, 16'h0000, TCAC_VM_PURGE);
        vp = 16'h0000;
        i_host.wr(TCAC_IDX_STATUS, 16'h0000);
        step(3);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        ochk(2'b00, hsp, TCAC_VM_PURGE);
        // Sensor failure alarm.
        sf = 1'b1;
        step(4);
        rchk(TCAC_IDX_STATUS, 16'h0008);
        i_host.wr(TCAC_IDX_STATUS, 16'h0000);
        rchk(TCAC_IDX_STATUS, 16'h0008);
        i_host.wr(TCAC_IDX_CTRL, 16'h0200);
        step(2);
        rchk(TCAC_IDX_STATUS, 16'h0000);
        tally_and_finish();
    end
endmodule : testbench
